// ### rtl/pasio_port.sv
// The register addresses and register access over APB were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "pasio_cfg.svh"

// Summary of operation
// - Five pin positions, drivers of pins four and five individually switchable.
// - Direction one disables driver, zero drives latch.
// - Pins zero, one, three are input only.
// - Latch write equals pin value write.
// - Latch reads latch, pin register reads pins.
// - Pin writes load the written bits straight into latch.
// - Peripheral owns pin output, level stays readable.
// - Analog select forces digital reads to zero.
// - Analog select leaves digital output working.
// - Direction bits still control analog pins' drivers.
// - Analog select resets to analog.
// - Steering never changes direction bits.
// - Bit 7 moves reference clock output.
// - Bit 6 moves serial data output.
// - Bit 5 moves select input.
// - Bit 3 moves timer gate input.
// - Bit 2 moves second PWM output.
// - Highest priority output function owns pin.
// - Only direction bits five, four writable.
// - Single analog select bit at position four.
module pasio_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic variant_14pin,
  input wire logic [5:0] pin_in,
  output logic [5:0] pin_out,
  output logic [5:0] pin_oe_n,
  input wire logic third_port_pin3_in,
  input wire logic third_port_pin6_in,
  input wire logic clkout_en,
  input wire logic clkout_val,
  input wire logic sosco_en,
  input wire logic sosco_val,
  input wire logic reference_clock_out_en,
  input wire logic reference_clock_out,
  input wire logic serial_out_en,
  input wire logic serial_out,
  input wire logic second_pwm_output_en,
  input wire logic second_pwm_output,
  output logic third_port_pin2_ovr_en,
  output logic third_port_pin2_ovr_val,
  output logic third_port_pin3_ovr_en,
  output logic third_port_pin3_ovr_val,
  output logic timer_gate_input,
  output logic select_input
);

  import pasio_pkg::*;

  // ****************************************************************
  // Declarations.
  // ****************************************************************
  pasio_state_s s_ff;
  pasio_state_s nxt_s;
  logic [7:0] sync_raw;
  logic [7:0] pin_rd;
  logic [7:0] steer_eff;
  logic acc_wr;

  // ****************************************************************
  // Functions.
  // ****************************************************************

  // Pin value register image: analog pin four reads zero.
  function automatic logic [7:0] pin_image(input logic [7:0] sp, input logic ans);
    logic [7:0] img;
    img = 8'h00;
    img[`PASIO_PIN0] = sp[`PASIO_PIN0];
    img[`PASIO_PIN1] = sp[`PASIO_PIN1];
    img[`PASIO_PIN3] = sp[`PASIO_PIN3];
    img[`PASIO_PIN4] = sp[`PASIO_PIN4] & ~ans;
    img[`PASIO_PIN5] = sp[`PASIO_PIN5];
    return img;
  endfunction

  // Merges written data over the sampled pin image, lane by lane.
  function automatic logic [1:0] rmw_latch(input logic [7:0] img, input logic [7:0] wd,
                                           input logic lane);
    logic [7:0] merged;
    merged = lane ? wd : img;
    return merged[`PASIO_PIN5:`PASIO_PIN4];
  endfunction

  // Writable steering bits depend on the package variant.
  function automatic logic [7:0] steer_mask(input logic v14);
    return v14 ? `PASIO_STEER_MASK14 : `PASIO_STEER_MASK20;
  endfunction

  // Address decode used by the error path only.
  function automatic logic addr_hit(input logic [7:0] a);
    return (a == `PASIO_OFF_PINVAL) || (a == `PASIO_OFF_LATCH) || (a == `PASIO_OFF_DIR) ||
           (a == `PASIO_OFF_ANSEL) || (a == `PASIO_OFF_STEER);
  endfunction

  // ****************************************************************
  // Pin synchroniser.
  // ****************************************************************

  pasio_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({third_port_pin6_in, third_port_pin3_in, pin_in}),
    .sync_out(sync_raw)
  );

  // Digital image of the pins as software sees it.
  assign pin_rd = pin_image(sync_raw, s_ff.ans);

  // Steering bits that exist on the present variant; the others read and act as zero.
  assign steer_eff = s_ff.steer & steer_mask(variant_14pin);

  // Completion edge of an APB write.
  assign acc_wr = psel && penable && s_ff.pready && pwrite && !s_ff.pslverr;

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************

  // Bus slave, register writes and pin steering in one pass.
  always_comb begin
    nxt_s = s_ff;

    // APB: setup is answered with pready in the access cycle.
    unique case (s_ff.apb_st)
      PASIO_IDLE: begin
        if (psel && !penable) begin
          nxt_s.apb_st = PASIO_ACK;
          nxt_s.pready = 1'h1;
          nxt_s.pslverr = !addr_hit(paddr);
          nxt_s.prdata = 32'h0000_0000;
          unique case (paddr)
            `PASIO_OFF_PINVAL: nxt_s.prdata[7:0] = pin_rd;
            `PASIO_OFF_LATCH: begin
              nxt_s.prdata[`PASIO_PIN5:`PASIO_PIN4] = s_ff.lat;
            end
            `PASIO_OFF_DIR: begin
              nxt_s.prdata[7:0] = `PASIO_DIR_FIXED;
              nxt_s.prdata[`PASIO_DIR_HI:`PASIO_DIR_LO] = s_ff.dir;
            end
            `PASIO_OFF_ANSEL: nxt_s.prdata[`PASIO_ANS_BIT] = s_ff.ans;
            `PASIO_OFF_STEER: nxt_s.prdata[7:0] = steer_eff;
            default: nxt_s.prdata = 32'h0000_0000;
          endcase
        end
      end
      PASIO_ACK: begin
        nxt_s.apb_st = PASIO_IDLE;
        nxt_s.pready = 1'h0;
        nxt_s.pslverr = 1'h0;
      end
    endcase

    if (acc_wr && pstrb[0]) begin
      unique case (paddr)
        `PASIO_OFF_PINVAL, `PASIO_OFF_LATCH: begin
          nxt_s.lat = rmw_latch(pin_rd, pwdata[7:0], pstrb[0]);
        end
        `PASIO_OFF_DIR: nxt_s.dir = pwdata[`PASIO_DIR_HI:`PASIO_DIR_LO];
        `PASIO_OFF_ANSEL: nxt_s.ans = pwdata[`PASIO_ANS_BIT];
        `PASIO_OFF_STEER: nxt_s.steer = pwdata[7:0] & steer_mask(variant_14pin);
        default: nxt_s.lat = s_ff.lat;
      endcase
    end

    nxt_s.pin_oe_n = 6'h3f;
    nxt_s.pin_out = 6'h00;

    nxt_s.pin_oe_n[`PASIO_PIN4] = s_ff.dir[0];
    nxt_s.pin_oe_n[`PASIO_PIN5] = s_ff.dir[1];

    if (clkout_en) begin
      nxt_s.pin_out[`PASIO_PIN4] = clkout_val;
    end else if (sosco_en) begin
      nxt_s.pin_out[`PASIO_PIN4] = sosco_val;
    end else if (reference_clock_out_en && !s_ff.steer[`PASIO_ST_REFERENCE_CLOCK_OUT]) begin
      nxt_s.pin_out[`PASIO_PIN4] = reference_clock_out;
    end else if (serial_out_en && steer_eff[`PASIO_ST_SDO]) begin
      nxt_s.pin_out[`PASIO_PIN4] = serial_out;
    end else begin
      nxt_s.pin_out[`PASIO_PIN4] = s_ff.lat[0];
    end

    if (second_pwm_output_en && steer_eff[`PASIO_ST_SECOND_PWM_OUTPUT]) begin
      nxt_s.pin_out[`PASIO_PIN5] = second_pwm_output;
    end else begin
      nxt_s.pin_out[`PASIO_PIN5] = s_ff.lat[1];
    end

    nxt_s.rc2_ovr_en = serial_out_en && !s_ff.steer[`PASIO_ST_SDO] && variant_14pin;
    nxt_s.rc2_ovr_val = serial_out;

    if (reference_clock_out_en && s_ff.steer[`PASIO_ST_REFERENCE_CLOCK_OUT]) begin
      nxt_s.rc3_ovr_en = 1'h1;
      nxt_s.rc3_ovr_val = reference_clock_out;
    end else begin
      nxt_s.rc3_ovr_en = second_pwm_output_en && !s_ff.steer[`PASIO_ST_SECOND_PWM_OUTPUT] &&
                         variant_14pin;
      nxt_s.rc3_ovr_val = second_pwm_output;
    end

    nxt_s.tgate = s_ff.steer[`PASIO_ST_TGATE] ? pin_rd[`PASIO_PIN3] : pin_rd[`PASIO_PIN4];

    if (s_ff.steer[`PASIO_ST_SS]) begin
      nxt_s.ssel = pin_rd[`PASIO_PIN3];
    end else if (variant_14pin) begin
      nxt_s.ssel = sync_raw[`PASIO_SYNC_RC3];
    end else begin
      nxt_s.ssel = sync_raw[`PASIO_SYNC_RC6];
    end
  end

  // ****************************************************************
  // State register.
  // ****************************************************************

  // Registers the whole state; reset loads constants only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '0;
      s_ff.apb_st <= PASIO_IDLE;
      s_ff.dir <= `PASIO_RST_DIR;
      s_ff.lat <= `PASIO_RST_LAT;
      s_ff.ans <= `PASIO_RST_ANS;
      s_ff.steer <= `PASIO_RST_STEER;
      s_ff.pin_oe_n <= 6'h3f;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ****************************************************************
  // Outputs, all straight from flip-flops.
  // ****************************************************************

  // Bus answer.
  assign prdata = s_ff.prdata;
  assign pready = s_ff.pready;
  assign pslverr = s_ff.pslverr;

  // Pins and routed peripheral signals.
  assign pin_out = s_ff.pin_out;
  assign pin_oe_n = s_ff.pin_oe_n;
  assign third_port_pin2_ovr_en = s_ff.rc2_ovr_en;
  assign third_port_pin2_ovr_val = s_ff.rc2_ovr_val;
  assign third_port_pin3_ovr_en = s_ff.rc3_ovr_en;
  assign third_port_pin3_ovr_val = s_ff.rc3_ovr_val;
  assign timer_gate_input = s_ff.tgate;
  assign select_input = s_ff.ssel;

  // ****************************************************************
  // Assertions.
  // ****************************************************************

  default clocking cb @(posedge pclk);
  endclocking

  default disable iff (!presetn);

  // Input-only pins never drive.
  input_only_a: assert property (
    pin_oe_n[`PASIO_PIN3:`PASIO_PIN0] == `PASIO_INPUT_ONLY)
    else $error("input-only pin driven");

  // Setup phase is answered in the next cycle.
  apb_answer_a: assert property (
    (psel && !penable && !pready) |=> pready ##1 !pready)
    else $error("apb answer timing wrong");

  // Direction readback carries fixed bits.
  dir_readback_a: assert property (
    (psel && !penable && !pready && !pwrite && paddr == `PASIO_OFF_DIR) |=>
    (prdata[3:0] == 4'(`PASIO_DIR_FIXED)) && (prdata[7:6] == 2'h0))
    else $error("direction readback wrong");

  // Clearing a direction bit enables the driver two edges later.
  dir_drive_a: assert property (
    (acc_wr && pstrb[0] && paddr == `PASIO_OFF_DIR && !pwdata[`PASIO_PIN4]) |=>
    ##1 !pin_oe_n[`PASIO_PIN4])
    else $error("driver not enabled");

  // Both latch addresses load the written bits.
  latch_write_a: assert property (
    (acc_wr && pstrb[0] && (paddr == `PASIO_OFF_LATCH || paddr == `PASIO_OFF_PINVAL))
    |=> s_ff.lat == $past(pwdata[`PASIO_PIN5:`PASIO_PIN4]))
    else $error("latch not loaded");

  // Analog pin four reads zero.
  analog_zero_a: assert property (
    (s_ff.ans && psel && !penable && !pready && !pwrite && paddr == `PASIO_OFF_PINVAL)
    |=> !prdata[`PASIO_PIN4])
    else $error("analog pin read as one");

  // Clock out wins pin four.
  prio_clkout_a: assert property (
    clkout_en |=> pin_out[`PASIO_PIN4] == $past(clkout_val))
    else $error("pin four priority wrong");

  // Reference clock goes to the alternate pin when steered.
  reference_clock_out_steer_a: assert property (
    (reference_clock_out_en && s_ff.steer[`PASIO_ST_REFERENCE_CLOCK_OUT]) |=>
    third_port_pin3_ovr_en && third_port_pin3_ovr_val == $past(reference_clock_out))
    else $error("reference clock not steered");

  // Timer gate follows pin four while bit 3 is clear.
  tgate_steer_a: assert property (
    (!s_ff.steer[`PASIO_ST_TGATE]) |=> timer_gate_input == $past(pin_rd[`PASIO_PIN4]))
    else $error("timer gate source wrong");

endmodule

`default_nettype wire

// ### rtl/pasio_cfg.svh
`ifndef PASIO_CFG_SVH
`define PASIO_CFG_SVH

// ****************************************************************
// Register byte offsets on the APB bus.
// ****************************************************************
`define PASIO_OFF_PINVAL 8'h00
`define PASIO_OFF_LATCH 8'h04
`define PASIO_OFF_DIR 8'h08
`define PASIO_OFF_ANSEL 8'h0c
`define PASIO_OFF_STEER 8'h10

// ****************************************************************
// Reset values.
// ****************************************************************
`define PASIO_RST_DIR 2'h3
`define PASIO_RST_LAT 2'h0
`define PASIO_RST_ANS 1'h1
`define PASIO_RST_STEER 8'h00

// ****************************************************************
// Field positions and fixed read values.
// ****************************************************************
`define PASIO_DIR_FIXED 8'h0b
`define PASIO_DIR_LO 4
`define PASIO_DIR_HI 5
`define PASIO_ANS_BIT 4
`define PASIO_STEER_MASK14 8'hec
`define PASIO_STEER_MASK20 8'ha8
`define PASIO_ST_REFERENCE_CLOCK_OUT 7
`define PASIO_ST_SDO 6
`define PASIO_ST_SS 5
`define PASIO_ST_TGATE 3
`define PASIO_ST_SECOND_PWM_OUTPUT 2
`define PASIO_PIN0 0
`define PASIO_PIN1 1
`define PASIO_PIN3 3
`define PASIO_PIN4 4
`define PASIO_PIN5 5
`define PASIO_SYNC_RC3 6
`define PASIO_SYNC_RC6 7
`define PASIO_SYNC_W 8
`define PASIO_INPUT_ONLY 4'hf

`endif

// ### rtl/pasio_pkg.sv
package pasio_pkg;

  // Phase of the APB slave.
  typedef enum logic [0:0] {
    PASIO_IDLE,
    PASIO_ACK
  } pasio_apb_e;

  // Whole state of the port block.
  typedef struct packed {
    pasio_apb_e apb_st;
    logic [1:0] dir;
    logic [1:0] lat;
    logic ans;
    logic [7:0] steer;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [5:0] pin_out;
    logic [5:0] pin_oe_n;
    logic rc2_ovr_en;
    logic rc2_ovr_val;
    logic rc3_ovr_en;
    logic rc3_ovr_val;
    logic tgate;
    logic ssel;
  } pasio_state_s;

endpackage

// ### rtl/pasio_sync.sv
`timescale 1ns/100ps
`default_nettype none
`include "pasio_cfg.svh"

// Two-stage synchroniser for the pin levels; only stage two is read.
module pasio_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] async_in,
  output logic [7:0] sync_out
);

  logic [7:0] meta_ff;
  logic [7:0] sync_ff;

  genvar i;
  generate
    for (i = 0; i < `PASIO_SYNC_W; i++) begin : g_bit
      // Each bit passes two flip-flops before any logic sees it.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_ff[i] <= 1'h0;
          sync_ff[i] <= 1'h0;
        end else begin
          meta_ff[i] <= async_in[i];
          sync_ff[i] <= meta_ff[i];
        end
      end
    end
  endgenerate

  assign sync_out = sync_ff;

endmodule

`default_nettype wire

// ### tb/pasio_pins.sv
`timescale 1ns/100ps
`default_nettype none

// ************
// Pin model
// ************
module pasio_pins (
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe_n,
  input wire logic [5:0] ext_lvl,
  output logic [5:0] pin_in
);
  // driver owns wire
  // A driven pin shows the port's level, a released pin the outside level.
  assign pin_in = (pin_out & ~pin_oe_n) | (ext_lvl & pin_oe_n);
endmodule

`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "pasio_cfg.svh"

module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd_data;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, rd_err, v14 = 1, tp3 = 0, tp6 = 1;
  logic [9:0] pv = 10'h000;
  logic [5:0] ext = 6'h3b, pin_in, pin_out, pin_oe_n;
  logic tp2_en, tp2_v, tp3_en, tp3_v, tgate, ssel;
  int err_count = 0, n_checks = 0;

  // Free-running 50 MHz clock.
  initial forever #10 pclk = ~pclk;

  // ************
  // Design and pins
  // ************
  pasio_port u_pasio_port (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .variant_14pin(v14), .pin_in, .pin_out,
    .pin_oe_n, .third_port_pin3_in(tp3), .third_port_pin6_in(tp6),
    .clkout_en(pv[0]), .clkout_val(pv[1]), .sosco_en(pv[2]), .sosco_val(pv[3]),
    .reference_clock_out_en(pv[4]), .reference_clock_out(pv[5]),
    .serial_out_en(pv[6]), .serial_out(pv[7]),
    .second_pwm_output_en(pv[8]), .second_pwm_output(pv[9]),
    .third_port_pin2_ovr_en(tp2_en), .third_port_pin2_ovr_val(tp2_v),
    .third_port_pin3_ovr_en(tp3_en), .third_port_pin3_ovr_val(tp3_v),
    .timer_gate_input(tgate), .select_input(ssel));

  pasio_pins u_pasio_pins (.pin_out, .pin_oe_n, .ext_lvl(ext), .pin_in);

  // ************
  // Tasks
  // ************
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask

  // One APB transfer; pready is sampled at the rising edge, as the slave sees it.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= wr;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1) begin
      err_count++;
      conclude();
    end
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 8'h00);
    chk(nm, exp, rd_data);
  endtask

  // Waits past the two sync stages and the output register.
  task automatic settle();
    repeat (5) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic setp(input logic [9:0] v);
    @(posedge pclk);
    pv <= v;
    settle();
  endtask

  // Changes the package variant on a rising edge.
  task automatic setv(input logic v);
    @(posedge pclk);
    v14 <= v;
  endtask

  // ************
  // Main sequence
  // ************
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    chk("oe_rst", 32'h3f, {26'h0, pin_oe_n});
    rd(`PASIO_OFF_DIR, 32'h3b, "dir_rst");
    rd(`PASIO_OFF_ANSEL, 32'h10, "ans_rst");
    rd(`PASIO_OFF_STEER, 32'h00, "st_rst");
    rd(`PASIO_OFF_PINVAL, 32'h2b, "pin_ana");
    apb(1'b1, `PASIO_OFF_DIR, 8'h00);
    rd(`PASIO_OFF_DIR, 32'h0b, "dir_w");
    apb(1'b1, `PASIO_OFF_ANSEL, 8'h00);
    apb(1'b1, `PASIO_OFF_PINVAL, 8'h10);
    rd(`PASIO_OFF_LATCH, 32'h10, "lat_pv");
    settle();
    chk("oe_out", 32'h0f, {26'h0, pin_oe_n});
    chk("out_lat", 32'h10, {26'h0, pin_out});
    rd(`PASIO_OFF_PINVAL, 32'h1b, "pin_drv");
    apb(1'b1, `PASIO_OFF_LATCH, 8'h30);
    rd(`PASIO_OFF_LATCH, 32'h30, "lat_w");
    pstrb <= 4'he;
    apb(1'b1, `PASIO_OFF_LATCH, 8'h00);
    pstrb <= 4'hf;
    rd(`PASIO_OFF_LATCH, 32'h30, "lat_strb");
    apb(1'b1, `PASIO_OFF_ANSEL, 8'h10);
    settle();
    chk("out_ana", 32'h30, {26'h0, pin_out});
    chk("oe_ana", 32'h0f, {26'h0, pin_oe_n});
    rd(`PASIO_OFF_PINVAL, 32'h2b, "pin_ana2");
    apb(1'b1, 8'h14, 8'h55);
    chk("unmapped_err", 32'h1, {31'h0, rd_err});
    apb(1'b1, `PASIO_OFF_STEER, 8'hff);
    rd(`PASIO_OFF_STEER, 32'hec, "st14");
    setv(1'b0);
    rd(`PASIO_OFF_STEER, 32'ha8, "st20");
    rd(`PASIO_OFF_DIR, 32'h0b, "dir_st");
    settle();
    chk("ssel_p3", 32'h1, {31'h0, ssel});
    chk("tg_p3", 32'h1, {31'h0, tgate});
    setv(1'b1);
    apb(1'b1, `PASIO_OFF_STEER, 8'h80);
    setp(10'h030);
    chk("rc3_en", 32'h1, {31'h0, tp3_en});
    chk("rc3_v", 32'h1, {31'h0, tp3_v});
    apb(1'b1, `PASIO_OFF_STEER, 8'h00);
    setp(10'h010);
    chk("out_ref", 32'h20, {26'h0, pin_out});
    setp(10'h013);
    chk("out_prio", 32'h30, {26'h0, pin_out});
    chk("tg_p4", 32'h0, {31'h0, tgate});
    chk("ssel_rc3", 32'h0, {31'h0, ssel});
    setv(1'b0);
    settle();
    chk("ssel_rc6", 32'h1, {31'h0, ssel});
    setv(1'b1);
    setp(10'h0c0);
    chk("rc2_en", 32'h1, {31'h0, tp2_en});
    chk("rc2_v", 32'h1, {31'h0, tp2_v});
    chk("out_sdo", 32'h30, {26'h0, pin_out});
    apb(1'b1, `PASIO_OFF_STEER, 8'h04);
    setp(10'h100);
    chk("out_pwm", 32'h10, {26'h0, pin_out});
    // A reset in mid-run brings the registers back to their reset values.
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    chk("oe_rst2", 32'h3f, {26'h0, pin_oe_n});
    rd(`PASIO_OFF_ANSEL, 32'h10, "ans_rst2");
    rd(`PASIO_OFF_LATCH, 32'h00, "lat_rst2");
    conclude();
  end
endmodule

`default_nettype wire
